//--- civ_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// host processor side of the acknowledge handshake
module civ_host_model
    import civ_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // from the block
    input wire logic arb_req_in,
    input wire logic [7:0] vector_in,
    input wire logic vector_valid_in,
    // to the block
    output logic int_ack_cycle_out,
    output logic [2:0] ack_level_out,
    output logic arb_win_out
);
    // idle: no cycle, level shows garbage on purpose
    initial begin
        int_ack_cycle_out = 1'b0;
        ack_level_out = 3'h7;
        arb_win_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // one acknowledge cycle; slow delays the arbitration win
    task automatic ack(input logic [2:0] lvl, input int slow,
                       output logic [7:0] vec, output logic ok);
        int n;
        ok = 1'b0;
        vec = 8'h00;
        int_ack_cycle_out <= 1'b1;
        ack_level_out <= lvl;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge mclk_in);
            // vector taken at the edge that shows it
            if (vector_valid_in === 1'b1) begin
                vec = vector_in;
                ok = 1'b1;
            end else if (arb_req_in === 1'b1 && n >= slow) begin
                arb_win_out <= 1'b1;
            end
        end
        // cycle must end before another may start
        int_ack_cycle_out <= 1'b0;
        arb_win_out <= 1'b0;
        ack_level_out <= ~lvl;
        @(posedge mclk_in);
    endtask
endmodule

//--- civ_irq_vector.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module civ_irq_vector
    import civ_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // source events from the protocol engine
    input wire logic [NUM_BUF-1:0] buf_done_in,
    input wire logic busoff_event_in,
    input wire logic error_event_in,
    input wire logic can_rx_in,
    // activity and mode status
    input wire logic frame_active_in,
    input wire logic sbuf_xfer_in,
    input wire logic tx_pending_in,
    input wire logic debug_mode_in,
    input wire logic stop_mode_in,
    input wire logic busoff_state_in,
    // intermodule bus interrupt side
    input wire logic int_ack_cycle_in,
    input wire logic [2:0] ack_level_in,
    input wire logic arb_win_in,
    output logic [2:0] irq_level_out,
    output logic arb_req_out,
    output logic [7:0] vector_out,
    output logic vector_valid_out,
    // clock gate and block interrupt
    output logic clk_gate_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////
    // storage
    logic auto_power_save_enable; // auto_power_save_enable
    logic wake_int_mask;
    logic [2:0] request_level_field;
    logic [2:0] vector_base_field;
    logic [NUM_BUF-1:0] buffer_int_mask;
    logic [NUM_BUF-1:0] buffer_int_flag;
    logic [NUM_BUF-1:0] buf_armed; // bits seen set by a flag read
    logic busoff_int_mask;
    logic error_int_mask;
    logic [NUM_ES-1:0] error_status_reg;
    logic [NUM_ES-1:0] es_armed;
    logic [NUM_EV-1:0] ev_status; // sticky block events
    logic [NUM_EV-1:0] ev_mask;
    logic rx_prev; // last bus level for edge detect
    civ_ack_e ack_state;
    // decoded helpers
    logic rd_take; // first access cycle, data latched
    logic wr_do; // completing write edge
    logic idle_all;
    logic [NUM_ES-1:0] es_event;
    logic [NUM_SRC-1:0] pending;
    logic req_any;
    logic [4:0] src_code;
    logic [31:0] rd_mux;
    logic next_gate;
    logic vec_fire;

    ////////////////////////////////////////////////////////////////////
    // read-then-write-zero clear; a same-cycle event always wins
    function automatic logic [NUM_BUF-1:0] clear_flags(
        input logic [NUM_BUF-1:0] flag,
        input logic [NUM_BUF-1:0] armed,
        input logic [NUM_BUF-1:0] wdata,
        input logic [NUM_BUF-1:0] ev
    );
        clear_flags = (flag & ~(armed & ~wdata)) | ev;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, writes act on the completing edge
    assign rd_take = psel_in && penable_in && !pready_out;
    assign wr_do = psel_in && penable_in && pready_out && pwrite_in;

    // read mux, reserved bits read zero
    always_comb begin
        rd_mux = RDATA_RST;
        case (paddr_in)
            MCR_OFF: begin
                rd_mux[MCR_APS_BIT] = auto_power_save_enable;
                rd_mux[MCR_WAKE_INT_MASK_BIT] = wake_int_mask;
                rd_mux[MCR_GATED_BIT] = clk_gate_out;
            end
            ICR_OFF: begin
                rd_mux[ICR_LVL_LSB +: 3] = request_level_field;
                rd_mux[ICR_BASE_LSB +: 3] = vector_base_field;
            end
            BMASK_OFF: rd_mux[NUM_BUF-1:0] = buffer_int_mask;
            BFLAG_OFF: rd_mux[NUM_BUF-1:0] = buffer_int_flag;
            CTRL0_OFF: begin
                rd_mux[CTRL0_BOFF_BIT] = busoff_int_mask;
                rd_mux[CTRL0_ERR_BIT] = error_int_mask;
            end
            ERROR_STATUS_REG_OFF: rd_mux[NUM_ES-1:0] = error_status_reg;
            ISTAT_OFF: rd_mux[NUM_EV-1:0] = ev_status;
            IMASKR_OFF: rd_mux[NUM_EV-1:0] = ev_mask;
            default: rd_mux = RDATA_RST;
        endcase
    end

    // bus answer flops
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            prdata_out <= RDATA_RST;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= rd_take;
            if (rd_take) begin
                prdata_out <= pwrite_in ? RDATA_RST : rd_mux;
                // unmapped or misaligned words answer with an error
                pslverr_out <= (paddr_in > IMASKR_OFF) ||
                               (paddr_in[1:0] != 2'b00);
            end else begin
                pslverr_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // plain control registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            auto_power_save_enable <= 1'b0;
            wake_int_mask <= 1'b0;
            request_level_field <= LVL_RST;
            vector_base_field <= BASE_RST;
            buffer_int_mask <= BUF_RST;
            busoff_int_mask <= 1'b0;
            error_int_mask <= 1'b0;
            ev_mask <= THREE_RST;
        end else if (wr_do) begin
            case (paddr_in)
                MCR_OFF: begin
                    auto_power_save_enable <= pwdata_in[MCR_APS_BIT];
                    wake_int_mask <= pwdata_in[MCR_WAKE_INT_MASK_BIT];
                end
                ICR_OFF: begin
                    request_level_field <= pwdata_in[ICR_LVL_LSB +: 3];
                    vector_base_field <= pwdata_in[ICR_BASE_LSB +: 3];
                end
                BMASK_OFF: buffer_int_mask <= pwdata_in[NUM_BUF-1:0];
                CTRL0_OFF: begin
                    busoff_int_mask <= pwdata_in[CTRL0_BOFF_BIT];
                    error_int_mask <= pwdata_in[CTRL0_ERR_BIT];
                end
                IMASKR_OFF: ev_mask <= pwdata_in[NUM_EV-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer flags: any finished transfer sets, tx and rx alike
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            buffer_int_flag <= BUF_RST;
            buf_armed <= BUF_RST;
        end else begin
            if (wr_do && paddr_in == BFLAG_OFF) begin
                buffer_int_flag <= clear_flags(buffer_int_flag, buf_armed,
                    pwdata_in[NUM_BUF-1:0], buf_done_in);
                buf_armed <= BUF_RST;
            end else begin
                buffer_int_flag <= buffer_int_flag | buf_done_in;
                // a new event between read and write cancels the clear
                if (rd_take && !pwrite_in && paddr_in == BFLAG_OFF)
                    buf_armed <= buffer_int_flag & ~buf_done_in;
                else
                    buf_armed <= buf_armed & ~buf_done_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wake edge: recessive to dominant only counts in stop mode
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in)
            rx_prev <= 1'b1;
        else
            rx_prev <= can_rx_in;
    end

    assign es_event[ES_BOFF_BIT] = busoff_event_in;
    assign es_event[ES_ERR_BIT] = error_event_in;
    assign es_event[ES_WAKE_BIT] = stop_mode_in && rx_prev &&
                                   !can_rx_in;

    // status flags, cleared the same way as buffer flags
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            error_status_reg <= THREE_RST;
            es_armed <= THREE_RST;
        end else begin
            if (wr_do && paddr_in == ERROR_STATUS_REG_OFF) begin
                error_status_reg <= NUM_ES'(clear_flags(
                    NUM_BUF'(error_status_reg), NUM_BUF'(es_armed),
                    NUM_BUF'(pwdata_in[NUM_ES-1:0]),
                    NUM_BUF'(es_event)));
                es_armed <= THREE_RST;
            end else begin
                error_status_reg <= error_status_reg | es_event;
                if (rd_take && !pwrite_in && paddr_in == ERROR_STATUS_REG_OFF)
                    es_armed <= error_status_reg & ~es_event;
                else
                    es_armed <= es_armed & ~es_event;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request: nineteen flag-mask pairs into the encoder
    assign pending = {
        error_status_reg[ES_WAKE_BIT] & wake_int_mask,
        error_status_reg[ES_ERR_BIT] & error_int_mask,
        error_status_reg[ES_BOFF_BIT] & busoff_int_mask,
        buffer_int_flag & buffer_int_mask
    };

    civ_prio_enc u_enc (
        .pend_in(pending),
        .found_out(req_any),
        .code_out(src_code)
    );

    // level output, withdrawn once no pair remains
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in)
            irq_level_out <= LVL_RST;
        else if (req_any)
            irq_level_out <= request_level_field;
        else
            irq_level_out <= LVL_RST;
    end

    ////////////////////////////////////////////////////////////////////
    // acknowledge handler: match level, arbitrate, supply vector
    assign vec_fire = (ack_state == ACK_ARB) && arb_win_in &&
                      int_ack_cycle_in;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ack_state <= ACK_IDLE;
            arb_req_out <= 1'b0;
            vector_out <= {BASE_RST, CODE_RST};
            vector_valid_out <= 1'b0;
        end else begin
            vector_valid_out <= 1'b0;
            case (ack_state)
                ACK_IDLE: begin
                    // level 0 never requests, so it never matches
                    if (int_ack_cycle_in && req_any &&
                        ack_level_in == irq_level_out &&
                        irq_level_out != LVL_RST) begin
                        ack_state <= ACK_ARB;
                        arb_req_out <= 1'b1;
                    end
                end
                ACK_ARB: begin
                    if (vec_fire) begin
                        // code frozen at the winning edge
                        vector_out <= {vector_base_field, src_code};
                        vector_valid_out <= 1'b1;
                        arb_req_out <= 1'b0;
                        ack_state <= ACK_DONE;
                    end else if (!int_ack_cycle_in) begin
                        // another module won; cycle ended
                        arb_req_out <= 1'b0;
                        ack_state <= ACK_IDLE;
                    end
                end
                ACK_DONE: begin
                    if (!int_ack_cycle_in)
                        ack_state <= ACK_IDLE;
                end
                default: begin
                    ack_state <= ACK_IDLE;
                    arb_req_out <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // auto power save; host access counts as activity
    assign idle_all = !frame_active_in && !sbuf_xfer_in &&
                      !tx_pending_in && !psel_in && !debug_mode_in &&
                      !stop_mode_in && !busoff_state_in;
    assign next_gate = auto_power_save_enable && idle_all;

    // re-evaluated every cycle so ungating costs one edge
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in)
            clk_gate_out <= 1'b0;
        else
            clk_gate_out <= next_gate;
    end

    ////////////////////////////////////////////////////////////////////
    // block events: sticky, read clears, set wins
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ev_status <= THREE_RST;
        end else begin
            logic [NUM_EV-1:0] ev;
            ev = THREE_RST;
            ev[EV_GATE_ON_BIT] = next_gate && !clk_gate_out;
            ev[EV_GATE_OFF_BIT] = !next_gate && clk_gate_out;
            ev[EV_VECTOR_BIT] = vec_fire;
            if (rd_take && !pwrite_in && paddr_in == ISTAT_OFF)
                ev_status <= ev;
            else
                ev_status <= ev_status | ev;
        end
    end

    // single level interrupt
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(ev_status & ev_mask);
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_gate_on;
        @(posedge mclk_in) disable iff (!rst_n_in)
        auto_power_save_enable && idle_all |=> clk_gate_out;
    endproperty
    a_gate_on: assert property (p_gate_on)
        else $error("clock not gated while idle");

    property p_gate_block;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_active_in || tx_pending_in || psel_in || stop_mode_in)
        |=> !clk_gate_out;
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("clock gated while busy");

    property p_ungate;
        @(posedge mclk_in) disable iff (!rst_n_in)
        clk_gate_out && !idle_all |=> !clk_gate_out;
    endproperty
    a_ungate: assert property (p_ungate)
        else $error("clock not restarted");

    property p_level;
        @(posedge mclk_in) disable iff (!rst_n_in)
        req_any |=> irq_level_out == $past(request_level_field);
    endproperty
    a_level: assert property (p_level)
        else $error("wrong request level");

    property p_vector;
        @(posedge mclk_in) disable iff (!rst_n_in)
        vec_fire |=> vector_valid_out && !arb_req_out ##1 !vector_valid_out;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector not supplied once");

    property p_vec_fmt;
        @(posedge mclk_in) disable iff (!rst_n_in)
        vec_fire |=> vector_out == {$past(vector_base_field),
                                    $past(src_code)};
    endproperty
    a_vec_fmt: assert property (p_vec_fmt)
        else $error("vector format wrong");

    property p_buf_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        buf_done_in != BUF_RST |=>
        (buffer_int_flag & $past(buf_done_in)) == $past(buf_done_in);
    endproperty
    a_buf_set: assert property (p_buf_set)
        else $error("buffer flag not set");

    property p_keep;
        @(posedge mclk_in) disable iff (!rst_n_in)
        wr_do && paddr_in == BFLAG_OFF |=>
        (buffer_int_flag & $past(buffer_int_flag & ~buf_armed)) ==
        $past(buffer_int_flag & ~buf_armed);
    endproperty
    a_keep: assert property (p_keep)
        else $error("unarmed flag cleared");

    property p_wake;
        @(posedge mclk_in) disable iff (!rst_n_in)
        stop_mode_in && rx_prev && !can_rx_in |=>
        error_status_reg[ES_WAKE_BIT];
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake flag not set");

    property p_withdraw;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !req_any |=> irq_level_out == LVL_RST;
    endproperty
    a_withdraw: assert property (p_withdraw)
        else $error("level not withdrawn");
endmodule

//--- civ_pkg.sv
package civ_pkg;
    // apb register byte offsets
    localparam logic [7:0] MCR_OFF = 8'h00;
    localparam logic [7:0] ICR_OFF = 8'h04;
    localparam logic [7:0] BMASK_OFF = 8'h08;
    localparam logic [7:0] BFLAG_OFF = 8'h0C;
    localparam logic [7:0] CTRL0_OFF = 8'h10;
    localparam logic [7:0] ERROR_STATUS_REG_OFF = 8'h14;
    localparam logic [7:0] ISTAT_OFF = 8'h18;
    localparam logic [7:0] IMASKR_OFF = 8'h1C;
    // module config fields
    localparam int MCR_APS_BIT = 0;
    localparam int MCR_WAKE_INT_MASK_BIT = 1;
    localparam int MCR_GATED_BIT = 2;
    // interrupt config fields
    localparam int ICR_LVL_LSB = 0;
    localparam int ICR_BASE_LSB = 5;
    // control zero fields
    localparam int CTRL0_BOFF_BIT = 0;
    localparam int CTRL0_ERR_BIT = 1;
    // error status flag positions
    localparam int ES_BOFF_BIT = 0;
    localparam int ES_ERR_BIT = 1;
    localparam int ES_WAKE_BIT = 2;
    // block event status positions
    localparam int EV_GATE_ON_BIT = 0;
    localparam int EV_GATE_OFF_BIT = 1;
    localparam int EV_VECTOR_BIT = 2;
    // sizes
    localparam int NUM_BUF = 16;
    localparam int NUM_SRC = 19;
    localparam int NUM_ES = 3;
    localparam int NUM_EV = 3;
    // reset values
    localparam logic [2:0] LVL_RST = 3'h0;
    localparam logic [2:0] BASE_RST = 3'h0;
    localparam logic [15:0] BUF_RST = 16'h0000;
    localparam logic [2:0] THREE_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h00000000;
    localparam logic [4:0] CODE_RST = 5'h00;
    // interrupt-acknowledge handler states
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b00,
        ACK_ARB = 2'b01,
        ACK_DONE = 2'b10
    } civ_ack_e;
endpackage

//--- civ_prio_enc.sv
`timescale 1ns/1ps
// fixed-priority encoder: lowest source index wins
module civ_prio_enc
    import civ_pkg::*;
(
    // pending sources, bit 0 highest priority
    input wire logic [NUM_SRC-1:0] pend_in,
    // encoded result
    output logic found_out,
    output logic [4:0] code_out
);
    // scan from lowest priority upward so the highest one lands last
    always_comb begin
        found_out = 1'b0;
        code_out = CODE_RST;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend_in[i]) begin
                found_out = 1'b1;
                code_out = 5'(i); // index equals the low vector code
            end
        end
    end
endmodule

//--- test_civ_irq_vector.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module test_civ_irq_vector
    import civ_pkg::*;
;
    logic mclk = 1'b0, rst_n = 1'b0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, q;
    logic [15:0] bdone = 16'h0000;
    logic boff_ev = 0, err_ev = 0, rx = 1;
    logic [5:0] act = 6'h00; // activity levels, one per idle condition except host access
    logic [31:0] prdata;
    logic pready, pslverr, ack_c, win, arb_req, vvalid, gate, irq, e, ok;
    logic [2:0] ack_lvl, lvl;
    logic [7:0] vec;
    int failures = 0, checked = 0;
    always #4 mclk = ~mclk;
    civ_irq_vector dut_u (.mclk_in(mclk), .rst_n_in(rst_n),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .buf_done_in(bdone),
        .busoff_event_in(boff_ev), .error_event_in(err_ev),
        .can_rx_in(rx), .frame_active_in(act[0]), .sbuf_xfer_in(act[1]),
        .tx_pending_in(act[2]), .debug_mode_in(act[3]),
        .stop_mode_in(act[4]), .busoff_state_in(act[5]),
        .int_ack_cycle_in(ack_c), .ack_level_in(ack_lvl),
        .arb_win_in(win), .irq_level_out(lvl), .arb_req_out(arb_req),
        .vector_out(vec), .vector_valid_out(vvalid),
        .clk_gate_out(gate), .irq_out(irq));
    civ_host_model host_u (.mclk_in(mclk), .arb_req_in(arb_req),
        .vector_in(vec), .vector_valid_in(vvalid),
        .int_ack_cycle_out(ack_c), .ack_level_out(ack_lvl),
        .arb_win_out(win));
    ////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, seen);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 10; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        if (n == 10) begin
            failures++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////
    // gating follows enable and each of the six activity inputs
    task automatic t_gate();
        apb(1, IMASKR_OFF, 32'h1);
        apb(1, MCR_OFF, 32'h1);
        cyc(3);
        check("gate_on", 1, gate);
        check("ev_irq", 1, irq);
        for (int k = 0; k < 6; k++) begin
            act[k] <= 1'b1;
            cyc(2);
            check("gate_busy", 0, gate);
            act[k] <= 1'b0;
            cyc(2);
            check("gate_again", 1, gate);
        end
        apb(1, MCR_OFF, 32'h0);
        apb(0, ISTAT_OFF, 0);
        check("ev_stat", 3, q[1:0]);
        cyc(2);
        check("ev_irq_clr", 0, irq);
    endtask
    // all nineteen sources at once: serviced in fixed order
    task automatic t_vectors();
        logic [7:0] v;
        apb(1, ICR_OFF, 32'hA5); // base 5, level 5
        apb(1, BMASK_OFF, 32'hFFFF);
        apb(1, CTRL0_OFF, 32'h3);
        apb(1, MCR_OFF, 32'h2);
        act[4] <= 1'b1;
        bdone <= 16'hFFFF;
        boff_ev <= 1'b1;
        err_ev <= 1'b1;
        rx <= 1'b0;
        @(posedge mclk);
        {bdone, boff_ev, err_ev, act[4]} <= '0;
        rx <= 1'b1;
        cyc(3);
        host_u.ack(3'h2, 0, v, ok);
        check("ack_mismatch", 0, ok);
        for (int i = 0; i < NUM_SRC; i++) begin
            check("level", 5, lvl);
            host_u.ack(3'h5, i % 3, v, ok);
            check("ack_ok", 1, ok);
            check("vector", {3'h5, 5'(i)}, v);
            if (i < NUM_BUF) begin
                apb(0, BFLAG_OFF, 0);
                check("bflag", 32'hFFFF << i & 32'hFFFF, q);
                apb(1, BFLAG_OFF, q & ~(32'h1 << i));
            end else begin
                apb(0, ERROR_STATUS_REG_OFF, 0);
                check("error_status_reg", 32'h7 << (i - 16) & 32'h7, q);
                apb(1, ERROR_STATUS_REG_OFF, q & ~(32'h1 << (i - 16)));
            end
            cyc(2);
        end
        check("level_off", 0, lvl);
        // every supplied vector leaves a sticky event behind
        apb(0, ISTAT_OFF, 0);
        check("ev_vector", 4, q);
    endtask
    // masked buffer stays quiet; event between read and write wins
    task automatic t_mask_clear();
        apb(1, BMASK_OFF, 32'hFFEF);
        bdone[4] <= 1'b1;
        @(posedge mclk);
        bdone[4] <= 1'b0;
        cyc(3);
        check("masked", 0, lvl);
        apb(0, BFLAG_OFF, 0);
        check("bflag4", 32'h10, q);
        bdone[4] <= 1'b1;
        @(posedge mclk);
        bdone[4] <= 1'b0;
        apb(1, BFLAG_OFF, 32'h0);
        apb(0, BFLAG_OFF, 0);
        check("kept", 32'h10, q);
        apb(1, BFLAG_OFF, 32'h0);
        apb(0, BFLAG_OFF, 0);
        check("cleared", 0, q);
        apb(0, 8'h20, 0);
        check("unmapped_err", 1, e);
        check("unmapped_data", 0, q);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        @(posedge mclk);
        check("level_rst", 0, lvl);
        t_gate();
        t_vectors();
        t_mask_clear();
        summarize();
    end
endmodule
